// [inc/dp_slave_defines.vh]
// dp slave sequencer constants: state codes, telegram codes, timing
// assumes inclusion by bare name from logic files
`ifndef DP_SLAVE_DEFINES_VH
`define DP_SLAVE_DEFINES_VH

// ----------------------------------------------------------------
// telegram kinds as decoded by the receiver front end
// ----------------------------------------------------------------
`define TG_NONE 3'h0
`define TG_SET_ADDR 3'h1
`define TG_PARAM 3'h2
`define TG_CONFIG 3'h3
`define TG_GET_CONFIG 3'h4
`define TG_DIAG 3'h5
`define TG_DATA 3'h6
`define TG_READ_IO 3'h7

// ----------------------------------------------------------------
// one-hot sequencer states
// ----------------------------------------------------------------
`define ST_POWER_ON 4'h1
`define ST_WAIT_PRM 4'h2
`define ST_WAIT_CFG 4'h4
`define ST_DATA_EX 4'h8

// ----------------------------------------------------------------
// configuration verdicts from the application
// ----------------------------------------------------------------
`define CFG_OK 2'h0
`define CFG_BAD 2'h1
`define CFG_ADAPT 2'h2

// ----------------------------------------------------------------
// answer kinds and timing
// ----------------------------------------------------------------
`define ANS_NONE 3'h0
`define ANS_ACK 3'h1
`define ANS_REJECT 3'h2
`define ANS_CONFIG 3'h3
`define ANS_DIAG 3'h4
`define ANS_DATA 3'h5
`define ANS_IO 3'h6
`define DIAG_STD_OCTETS 6
// watchdog tick period in ns and the derived cycle count at 100 MHz
`define WD_TICK_NS 10000
`define CLK_NS 10
`define WD_TICK_CYC (`WD_TICK_NS / `CLK_NS)

`endif

// [logic/dp_slave_state_sequencer.v]
// dp slave protocol sequencer: address, parameter, configuration,
// data exchange, diagnostics, readback and watchdog fallback.
// assumes the receiver front end delivers one decoded telegram per
// tg_valid pulse and the application answers its requests by pulses.
`timescale 1ns/1ps
`include "dp_slave_defines.vh"

module dp_slave_state_sequencer #(
  parameter WD_W = 16,
  parameter ADDR_W = 7,
  parameter LEN_W = 8,
  parameter TICK_CYC = `WD_TICK_CYC
) (
  input wire mclk,
  input wire rst,
  input wire tg_valid,
  input wire [2:0] tg_kind,
  input wire [ADDR_W-1:0] tg_new_addr,
  input wire [WD_W-1:0] tg_wd_value,
  input wire tg_has_user_prm,
  input wire [LEN_W-1:0] tg_in_len,
  input wire [LEN_W-1:0] tg_out_len,
  input wire tg_from_owner,
  input wire prm_ok_internal,
  input wire app_prm_done,
  input wire app_prm_accept,
  input wire app_cfg_done,
  input wire [1:0] app_cfg_verdict,
  input wire [LEN_W-1:0] app_in_len,
  input wire [LEN_W-1:0] app_out_len,
  input wire diag_new,
  input wire diag_is_error,
  input wire [LEN_W-1:0] diag_user_len,
  output reg ans_valid_r,
  output reg [2:0] ans_kind_r,
  output reg [LEN_W-1:0] ans_len_r,
  output reg [7:0] diag_state_octet_r,
  output reg [ADDR_W-1:0] station_addr_r,
  output reg prm_ind_r,
  output reg cfg_ind_r,
  output reg [LEN_W-1:0] cfg_in_len_r,
  output reg [LEN_W-1:0] cfg_out_len_r,
  output reg [LEN_W-1:0] io_in_len_r,
  output reg [LEN_W-1:0] io_out_len_r,
  output reg diag_flag_r,
  output reg diag_err_r,
  output reg [3:0] state_r,
  output reg wd_expired_ev_r
);

  // ------------------------------------------------------------
  // local state
  // ------------------------------------------------------------
  reg [3:0] state_nxt;
  reg prm_pend_r;
  reg cfg_pend_r;
  reg [WD_W-1:0] wd_load_r;
  wire wd_tick;
  wire wd_expired;
  wire wd_arm;
  wire traffic_ok;
  wire tg_prm;
  wire tg_cfg;
  wire [LEN_W-1:0] diag_len;
  // standard octet count at answer width
  localparam [LEN_W-1:0] DIAG_STD = `DIAG_STD_OCTETS;

  assign tg_prm = tg_valid && (tg_kind == `TG_PARAM);
  assign tg_cfg = tg_valid && (tg_kind == `TG_CONFIG);
  // supervision runs once parameters are in
  assign wd_arm = (state_r == `ST_WAIT_CFG) || (state_r == `ST_DATA_EX);
  // in data exchange any telegram retriggers the watchdog; in config wait only config and diag telegrams do
  assign traffic_ok = tg_valid && wd_arm &&
    ((state_r == `ST_DATA_EX) || tg_cfg || (tg_kind == `TG_DIAG));
  // standard octets first, user bytes after them
  assign diag_len = diag_user_len + DIAG_STD;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  dp_tick_gen #(
    .PERIOD(TICK_CYC)
  ) u_tick (
    .mclk(mclk),
    .rst(rst),
    .tick_r(wd_tick)
  );

  dp_watchdog #(
    .WD_W(WD_W)
  ) u_wd (
    .mclk(mclk),
    .rst(rst),
    .arm(wd_arm),
    .retrig(traffic_ok),
    .load_val(wd_load_r),
    .tick(wd_tick),
    .expired_r(wd_expired)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      `ST_POWER_ON:
      begin
        if (tg_valid && tg_kind == `TG_SET_ADDR)
          state_nxt = `ST_WAIT_PRM;
        else if (tg_prm)
          state_nxt = `ST_WAIT_PRM;
      end
      `ST_WAIT_PRM:
      begin
        // app verdict closes the parameter phase
        if (prm_pend_r && app_prm_done && app_prm_accept && prm_ok_internal)
          state_nxt = `ST_WAIT_CFG;
      end
      `ST_WAIT_CFG:
      begin
        if (wd_expired)
          state_nxt = `ST_WAIT_PRM;
        else if (tg_prm)
          state_nxt = `ST_WAIT_PRM;
        else if (cfg_pend_r && app_cfg_done)
        begin
          if (app_cfg_verdict == `CFG_BAD)
            state_nxt = `ST_WAIT_PRM;
          else
            state_nxt = `ST_DATA_EX;
        end
      end
      `ST_DATA_EX:
      begin
        if (wd_expired)
          state_nxt = `ST_WAIT_PRM;
        else if (tg_prm)
          state_nxt = `ST_WAIT_PRM;
        else if (tg_cfg)
          state_nxt = `ST_WAIT_CFG;
      end
      default:
        state_nxt = `ST_POWER_ON;
    endcase
  end

  // ------------------------------------------------------------
  // state, pending phases, application indications
  // ------------------------------------------------------------
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= `ST_POWER_ON;
      prm_pend_r <= 1'b0;
      cfg_pend_r <= 1'b0;
      prm_ind_r <= 1'b0;
      cfg_ind_r <= 1'b0;
      wd_load_r <= {WD_W{1'b0}};
      station_addr_r <= {ADDR_W{1'b0}};
      cfg_in_len_r <= {LEN_W{1'b0}};
      cfg_out_len_r <= {LEN_W{1'b0}};
      io_in_len_r <= {LEN_W{1'b0}};
      io_out_len_r <= {LEN_W{1'b0}};
      wd_expired_ev_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      prm_ind_r <= 1'b0;
      cfg_ind_r <= 1'b0;
      wd_expired_ev_r <= wd_expired;
      if (state_r == `ST_POWER_ON && tg_valid && tg_kind == `TG_SET_ADDR)
        station_addr_r <= tg_new_addr;
      // a new parameter set wins over an app verdict in the same cycle for prm_pend_r; state_nxt still follows the verdict
      if (tg_prm)
      begin
        wd_load_r <= tg_wd_value;
        prm_pend_r <= 1'b1;
        cfg_pend_r <= 1'b0;
        prm_ind_r <= tg_has_user_prm;
      end
      else if (prm_pend_r && app_prm_done)
        prm_pend_r <= 1'b0;
      if (tg_cfg && (state_r == `ST_WAIT_CFG || state_r == `ST_DATA_EX))
      begin
        cfg_pend_r <= 1'b1;
        cfg_ind_r <= 1'b1;
        cfg_in_len_r <= tg_in_len;
        cfg_out_len_r <= tg_out_len;
      end
      else if (cfg_pend_r && app_cfg_done)
      begin
        cfg_pend_r <= 1'b0;
        if (app_cfg_verdict == `CFG_ADAPT)
        begin
          io_in_len_r <= app_in_len;
          io_out_len_r <= app_out_len;
        end
        else if (app_cfg_verdict == `CFG_OK)
        begin
          io_in_len_r <= cfg_in_len_r;
          io_out_len_r <= cfg_out_len_r;
        end
      end
      if (state_nxt == `ST_WAIT_PRM && state_r != `ST_WAIT_PRM)
        cfg_pend_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // diagnostics flag: a new report wins over the read that clears
  // ------------------------------------------------------------
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      diag_flag_r <= 1'b0;
      diag_err_r <= 1'b0;
    end
    else if (diag_new)
    begin
      diag_flag_r <= 1'b1;
      diag_err_r <= diag_is_error;
    end
    else if (tg_valid && tg_kind == `TG_DIAG)
    begin
      diag_flag_r <= 1'b0;
      diag_err_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // answers; owner is not checked for readbacks and diagnostics
  // ------------------------------------------------------------
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ans_valid_r <= 1'b0;
      ans_kind_r <= `ANS_NONE;
      ans_len_r <= {LEN_W{1'b0}};
      diag_state_octet_r <= 8'h00;
    end
    else
    begin
      ans_valid_r <= tg_valid;
      ans_kind_r <= `ANS_NONE;
      ans_len_r <= {LEN_W{1'b0}};
      diag_state_octet_r <= {diag_err_r, diag_flag_r, 2'h0, state_r};
      if (tg_valid)
      begin
        case (tg_kind)
          `TG_DIAG:
          begin
            ans_kind_r <= `ANS_DIAG;
            ans_len_r <= diag_len;
          end
          `TG_GET_CONFIG:
          begin
            ans_kind_r <= `ANS_CONFIG;
            ans_len_r <= io_in_len_r + io_out_len_r;
          end
          `TG_PARAM:
            ans_kind_r <= `ANS_ACK;
          `TG_SET_ADDR:
            ans_kind_r <= (state_r == `ST_POWER_ON) ? `ANS_ACK : `ANS_NONE;
          `TG_CONFIG:
            ans_kind_r <= (state_r == `ST_WAIT_PRM) ? `ANS_REJECT : `ANS_ACK;
          `TG_DATA:
          begin
            if (state_r == `ST_DATA_EX && tg_from_owner)
            begin
              ans_kind_r <= `ANS_DATA;
              ans_len_r <= io_in_len_r;
            end
            else
              ans_kind_r <= `ANS_REJECT;
          end
          `TG_READ_IO:
          begin
            if (state_r == `ST_DATA_EX)
            begin
              ans_kind_r <= `ANS_IO;
              ans_len_r <= io_in_len_r + io_out_len_r;
            end
            else
              ans_kind_r <= `ANS_REJECT;
          end
          default:
            ans_kind_r <= `ANS_REJECT;
        endcase
      end
    end
  end

endmodule

// [logic/dp_tick_gen.v]
// tick generator: one-cycle strobe every PERIOD clocks
// assumes mclk at 100 MHz
`timescale 1ns/1ps
`include "dp_slave_defines.vh"

module dp_tick_gen #(
  parameter PERIOD = `WD_TICK_CYC
) (
  input wire mclk,
  input wire rst,
  output reg tick_r
);

  reg [15:0] cnt_r;

  // ------------------------------------------------------------
  // free-running divider
  // ------------------------------------------------------------
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end
    else if (cnt_r == PERIOD[15:0] - 16'h0001)
    begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

endmodule

// [logic/dp_watchdog.v]
// response watchdog: loads a tick count, counts down, flags expiry
// assumes a free-running tick strobe from the parent
`timescale 1ns/1ps
`include "dp_slave_defines.vh"

module dp_watchdog #(
  parameter WD_W = 16
) (
  input wire mclk,
  input wire rst,
  input wire arm,
  input wire retrig,
  input wire [WD_W-1:0] load_val,
  input wire tick,
  output reg expired_r
);

  reg [WD_W-1:0] count_r;
  reg running_r;

  // ------------------------------------------------------------
  // countdown; a zero load value disables supervision
  // ------------------------------------------------------------
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      count_r <= {WD_W{1'b0}};
      running_r <= 1'b0;
      expired_r <= 1'b0;
    end
    else
    begin
      expired_r <= 1'b0;
      // disarmed: preload, so supervision runs from the full count once armed
      // even if no telegram ever arrives to retrigger it
      if (!arm)
      begin
        running_r <= (load_val != {WD_W{1'b0}});
        count_r <= load_val;
      end
      else if (retrig)
      begin
        count_r <= load_val;
        running_r <= (load_val != {WD_W{1'b0}});
      end
      else if (running_r && tick)
      begin
        if (count_r <= {{(WD_W-1){1'b0}}, 1'b1})
        begin
          expired_r <= 1'b1;
          running_r <= 1'b0;
        end
        else
          count_r <= count_r - {{(WD_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// [verif/dp_master_model.sv]
// bus master model: one decoded telegram per send call
// assumes calls come just after a falling edge of mclk
`timescale 1ns/1ps
module dp_master_model #(
  parameter ADDR_W = 7,
  parameter WD_W = 16,
  parameter LEN_W = 8
) (
  input wire mclk,
  output reg tg_valid,
  output reg [2:0] tg_kind,
  output reg [ADDR_W-1:0] tg_new_addr,
  output reg [WD_W-1:0] tg_wd_value,
  output reg tg_has_user_prm,
  output reg [LEN_W-1:0] tg_in_len,
  output reg [LEN_W-1:0] tg_out_len,
  output reg tg_from_owner
);
  // ----------------------------------------------------------------
  // telegram driver
  // ----------------------------------------------------------------
  initial
  begin
    tg_valid = 1'h0;
    {tg_kind, tg_new_addr, tg_wd_value, tg_has_user_prm} = '0;
    {tg_in_len, tg_out_len, tg_from_owner} = '0;
  end
  // fields held with the strobe through exactly one taking edge
  task send(input [2:0] k, input own, input [15:0] v);
    begin
      @(negedge mclk);
      tg_kind = k;
      tg_from_owner = own;
      tg_has_user_prm = own;
      tg_new_addr = v[ADDR_W-1:0];
      tg_wd_value = v[WD_W-1:0];
      tg_in_len = v[LEN_W-1:0];
      tg_out_len = v[15:16-LEN_W];
      tg_valid = 1'h1;
      @(negedge mclk);
      tg_valid = 1'h0;
      // idle fields except tg_has_user_prm churn, so the slave cannot lean on stale telegram data
      {tg_kind, tg_new_addr, tg_wd_value} = ~{tg_kind, tg_new_addr, tg_wd_value};
      {tg_in_len, tg_out_len, tg_from_owner} = ~{tg_in_len, tg_out_len, tg_from_owner};
    end
  endtask
endmodule

// [verif/dp_seq_sva.sv]
// concurrent checks on the dp slave sequencer ports
// assumes the defines header is on the include path; bound below
`timescale 1ns/1ps
`include "dp_slave_defines.vh"
module dp_seq_sva #(
  parameter ADDR_W = 7,
  parameter LEN_W = 8
) (
  input wire mclk,
  input wire rst,
  input wire tg_valid,
  input wire [2:0] tg_kind,
  input wire [LEN_W-1:0] tg_in_len,
  input wire prm_ok_internal,
  input wire app_prm_done,
  input wire app_prm_accept,
  input wire app_cfg_done,
  input wire [1:0] app_cfg_verdict,
  input wire diag_new,
  input wire diag_is_error,
  input wire [LEN_W-1:0] diag_user_len,
  input wire ans_valid_r,
  input wire [2:0] ans_kind_r,
  input wire [LEN_W-1:0] ans_len_r,
  input wire [ADDR_W-1:0] station_addr_r,
  input wire cfg_ind_r,
  input wire [LEN_W-1:0] cfg_in_len_r,
  input wire diag_flag_r,
  input wire diag_err_r,
  input wire [3:0] state_r,
  input wire wd_expired_ev_r
);
  // ----------------------------------------------------------------
  // state decode and step sequences
  // ----------------------------------------------------------------
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  wire in_pon = state_r == `ST_POWER_ON;
  wire in_prm = state_r == `ST_WAIT_PRM;
  wire in_cfg = state_r == `ST_WAIT_CFG;
  wire in_dx = state_r == `ST_DATA_EX;
  // expected diag length, wrapped to the answer width
  wire [LEN_W-1:0] dlen = diag_user_len + LEN_W'(`DIAG_STD_OCTETS);
  sequence s_prm_take;
    in_prm && app_prm_done && app_prm_accept && prm_ok_internal;
  endsequence
  sequence s_cfg_bad;
    in_cfg && app_cfg_done && app_cfg_verdict == `CFG_BAD;
  endsequence
  property p_addr_lock;
    tg_valid && tg_kind == `TG_SET_ADDR && !in_pon |=> $stable(station_addr_r);
  endproperty
  a_addr_lock: assert property (p_addr_lock) else $error("address moved late");
  property p_prm_rej;
    tg_valid && in_prm && (tg_kind == `TG_CONFIG || tg_kind == `TG_DATA)
      |=> ans_valid_r && ans_kind_r == `ANS_REJECT;
  endproperty
  a_prm_rej: assert property (p_prm_rej) else $error("no reject in prm wait");
  property p_cfg_show;
    tg_valid && in_cfg && tg_kind == `TG_CONFIG
      |=> cfg_ind_r && cfg_in_len_r == $past(tg_in_len);
  endproperty
  a_cfg_show: assert property (p_cfg_show) else $error("cfg not shown");
  property p_dx_entry;
    in_dx && !$past(in_dx)
      |-> $past(in_cfg) && $past(app_cfg_done) && $past(app_cfg_verdict) != `CFG_BAD;
  endproperty
  a_dx_entry: assert property (p_dx_entry) else $error("bad entry to dx");
  property p_diag_len;
    tg_valid && tg_kind == `TG_DIAG && !in_pon
      |=> ans_kind_r == `ANS_DIAG && ans_len_r == $past(dlen);
  endproperty
  a_diag_len: assert property (p_diag_len) else $error("diag answer wrong");
  property p_diag_flag;
    diag_new |=> diag_flag_r && diag_err_r == $past(diag_is_error);
  endproperty
  a_diag_flag: assert property (p_diag_flag) else $error("diag flag wrong");
  property p_io;
    tg_valid && tg_kind == `TG_READ_IO
      |=> ans_valid_r && ans_kind_r == ($past(in_dx) ? `ANS_IO : `ANS_REJECT);
  endproperty
  a_io: assert property (p_io) else $error("io readback wrong");
  property p_wd;
    $rose(wd_expired_ev_r) |-> ##[0:1] in_prm;
  endproperty
  a_wd: assert property (p_wd) else $error("no fallback on expiry");
  property p_prm_take;
    s_prm_take |=> in_cfg;
  endproperty
  a_prm_take: assert property (p_prm_take) else $error("no cfg wait");
  property p_cfg_bad;
    s_cfg_bad |=> in_prm ##1 in_prm;
  endproperty
  a_cfg_bad: assert property (p_cfg_bad) else $error("bad cfg kept");
endmodule
bind dp_slave_state_sequencer dp_seq_sva #(.ADDR_W(ADDR_W), .LEN_W(LEN_W)) u_sva (
  .mclk(mclk),
  .rst(rst),
  .tg_valid(tg_valid),
  .tg_kind(tg_kind),
  .tg_in_len(tg_in_len),
  .prm_ok_internal(prm_ok_internal),
  .app_prm_done(app_prm_done),
  .app_prm_accept(app_prm_accept),
  .app_cfg_done(app_cfg_done),
  .app_cfg_verdict(app_cfg_verdict),
  .diag_new(diag_new),
  .diag_is_error(diag_is_error),
  .diag_user_len(diag_user_len),
  .ans_valid_r(ans_valid_r),
  .ans_kind_r(ans_kind_r),
  .ans_len_r(ans_len_r),
  .station_addr_r(station_addr_r),
  .cfg_ind_r(cfg_ind_r),
  .cfg_in_len_r(cfg_in_len_r),
  .diag_flag_r(diag_flag_r),
  .diag_err_r(diag_err_r),
  .state_r(state_r),
  .wd_expired_ev_r(wd_expired_ev_r)
);

// [verif/tb_dp_slave_state_sequencer.sv]
// testbench for the dp slave sequencer; the bench plays the host
// and polls its event pulses; the master model drives telegrams
`timescale 1ns/1ps
`include "dp_slave_defines.vh"
module tb_dp_slave_state_sequencer;
  // ----------------------------------------------------------------
  // signals, model and design
  // ----------------------------------------------------------------
  reg mclk = 1'h0;
  reg rst = 1'h1;
  reg prm_ok_internal = 1'h1;
  reg app_prm_done = 1'h0;
  reg app_prm_accept = 1'h0;
  reg app_cfg_done = 1'h0;
  reg [1:0] app_cfg_verdict = 2'h0;
  reg [7:0] app_in_len = 8'h00;
  reg [7:0] app_out_len = 8'h00;
  reg [7:0] diag_user_len = 8'h00;
  reg diag_new = 1'h0;
  reg diag_is_error = 1'h0;
  wire tg_valid, tg_has_user_prm, tg_from_owner;
  wire [2:0] tg_kind, ans_kind_r;
  wire [6:0] tg_new_addr, station_addr_r;
  wire [15:0] tg_wd_value;
  wire [7:0] tg_in_len, tg_out_len, ans_len_r, diag_state_octet_r;
  wire [7:0] cfg_in_len_r, cfg_out_len_r, io_in_len_r, io_out_len_r;
  wire ans_valid_r, prm_ind_r, cfg_ind_r, diag_flag_r, diag_err_r, wd_expired_ev_r;
  wire [3:0] state_r;
  integer n_errors = 0;
  integer comparisons = 0;
  integer seed = 59;
  integer i;
  reg seen;
  reg [15:0] v;
  always #5 mclk = ~mclk;
  dp_master_model m (.*);
  // short tick keeps watchdog expiry within a few dozen cycles
  dp_slave_state_sequencer #(.TICK_CYC(4)) DUT (.*);
  task chk(input [15:0] got, input [15:0] want);
    begin
      comparisons = comparisons + 1;
      if (got !== want)
      begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h, want %h", $time, got, want);
      end
    end
  endtask
  task conclude;
    begin
      if (n_errors == 0 && comparisons > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  function [7:0] dlen(input [7:0] u);
    dlen = u + 8'(`DIAG_STD_OCTETS);
  endfunction
  task tg_ans(input [2:0] k, input own, input [2:0] a);
    begin
      m.send(k, own, v);
      chk({ans_valid_r, ans_kind_r}, {1'h1, a});
    end
  endtask
  // host verdict pulse: p picks parameter or configuration
  task app(input p, input [1:0] vd);
    begin
      @(negedge mclk);
      app_prm_done = p;
      app_prm_accept = vd[0];
      app_cfg_done = !p;
      app_cfg_verdict = vd;
      @(negedge mclk);
      app_prm_done = 1'h0;
      app_cfg_done = 1'h0;
    end
  endtask
  task diag(input e);
    begin
      @(negedge mclk);
      diag_new = 1'h1;
      diag_is_error = e;
      @(negedge mclk);
      diag_new = 1'h0;
    end
  endtask
  task to_cfg(input [15:0] w);
    begin
      m.send(`TG_PARAM, 1'h1, w);
      app(1'h1, 2'h1);
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(negedge mclk);
    rst = 1'h0;
    chk(state_r, `ST_POWER_ON);
    v = 16'($random(seed));
    tg_ans(`TG_SET_ADDR, 1'h1, `ANS_ACK);
    chk(station_addr_r, v[6:0]);
    m.send(`TG_PARAM, 1'h1, 16'h0003);
    chk(state_r, `ST_WAIT_PRM);
    m.send(`TG_SET_ADDR, 1'h1, ~v);
    chk({ans_valid_r, ans_kind_r, station_addr_r}, {1'h1, `ANS_NONE, v[6:0]});
    tg_ans(`TG_CONFIG, 1'h1, `ANS_REJECT);
    tg_ans(`TG_DATA, 1'h1, `ANS_REJECT);
    tg_ans(`TG_READ_IO, 1'h0, `ANS_REJECT);
    m.send(`TG_PARAM, 1'h1, 16'h0003);
    // the bench polls the event pulses instead of taking an interrupt
    chk(prm_ind_r, 1'h1);
    app(1'h1, 2'h0);
    chk(state_r, `ST_WAIT_PRM);
    // the application accepts but the internal check does not
    prm_ok_internal = 1'h0;
    to_cfg(16'h0003);
    chk(state_r, `ST_WAIT_PRM);
    prm_ok_internal = 1'h1;
    m.send(`TG_PARAM, 1'h0, 16'h0003);
    chk(prm_ind_r, 1'h0);
    app(1'h1, 2'h1);
    chk(state_r, `ST_WAIT_CFG);
    v = 16'($random(seed));
    m.send(`TG_CONFIG, 1'h1, v);
    chk({cfg_ind_r, cfg_out_len_r}, {1'h1, v[15:8]});
    app(1'h0, `CFG_BAD);
    chk(state_r, `ST_WAIT_PRM);
    to_cfg(16'h0003);
    m.send(`TG_CONFIG, 1'h1, v);
    app(1'h0, `CFG_OK);
    chk({state_r, io_in_len_r}, {`ST_DATA_EX, v[7:0]});
    tg_ans(`TG_GET_CONFIG, 1'h0, `ANS_CONFIG);
    chk(ans_len_r, 8'(v[7:0] + v[15:8]));
    tg_ans(`TG_READ_IO, 1'h0, `ANS_IO);
    chk(ans_len_r, 8'(v[7:0] + v[15:8]));
    tg_ans(`TG_DATA, 1'h1, `ANS_DATA);
    chk(ans_len_r, v[7:0]);
    diag_user_len = 8'($random(seed)) & 8'h3F;
    diag(1'h1);
    chk({diag_flag_r, diag_err_r}, 2'h3);
    tg_ans(`TG_DIAG, 1'h0, `ANS_DIAG);
    chk(ans_len_r, dlen(diag_user_len));
    chk(diag_state_octet_r, {1'h1, 1'h1, 2'h0, `ST_DATA_EX});
    chk(diag_flag_r, 1'h0);
    diag(1'h0);
    chk({diag_flag_r, diag_err_r}, 2'h2);
    // steady traffic must hold off the watchdog, silence must not
    for (i = 0; i < 8; i = i + 1)
      m.send(`TG_DATA, 1'h1, v);
    chk(state_r, `ST_DATA_EX);
    seen = 1'h0;
    for (i = 0; i < 40; i = i + 1)
    begin
      @(negedge mclk);
      if (wd_expired_ev_r === 1'h1)
        seen = 1'h1;
    end
    chk({seen, state_r}, {1'h1, `ST_WAIT_PRM});
    to_cfg(16'h0000);
    v = 16'($random(seed));
    app_in_len = v[7:0];
    app_out_len = v[15:8];
    m.send(`TG_CONFIG, 1'h1, ~v);
    app(1'h0, `CFG_ADAPT);
    chk({io_out_len_r, io_in_len_r}, v);
    chk(state_r, `ST_DATA_EX);
    conclude;
  end
  // watchdog on the bench itself: the run needs about 115 cycles
  initial
  begin
    #60000;
    n_errors = n_errors + 1;
    conclude;
  end
endmodule
